/* design/aclia_entry_mem.sv */
`timescale 1ns/1ps
`default_nettype none
// one byte lane of the rule table: all ports and entries
module aclia_entry_mem #(
  parameter int DEPTH = 80,
  parameter int AW = 7
)
(
  // clock
  input wire logic sys_clk_i,
  // write side
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [7:0] wdata_i,
  // read side
  input wire logic [AW-1:0] raddr_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [DEPTH];

  if (DEPTH > (1 << AW))
  begin : g_bad_depth
    $error("aclia_entry_mem: depth exceeds address range");
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (we_i)
      mem[waddr_i] <= wdata_i;
    rdata_o <= mem[raddr_i];
  end
endmodule // aclia_entry_mem
`default_nettype wire

/* design/aclia_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - index select: space 010, port 1-5
// - offset register routes data register accesses
// - control bit 6: write done, reset 1
// - control bit 5: read done, reset 1
// - control bit 4: 1 write, 0 read
// - control low nibble: entry index, reset 0
// - writing control byte launches transfer
// - second control bit 0: redundancy miss mode
// - buffer bytes at offsets 0x00 to 0x0D
// - table read honours byte mask
// - mask at 0x10 (upper six), 0x11 (lower eight)
// - index bit 4 gives host access direction
// - mask bit 0 is byte 0x0D, 13 byte 0x00
// - mask bit 1 includes byte, 0 excludes
module aclia_top #(
  parameter int PORTS = aclia_pkg::ACLIA_PORTS,
  parameter int ENTRIES = aclia_pkg::ACLIA_ENTRIES
)
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // host register port
  input wire aclia_pkg::aclia_req_s req_i,
  output logic [7:0] rdata_o,
  // configuration outputs
  output logic single_entry_redundancy_miss_o,
  output logic host_read_dir_o
);
  import aclia_pkg::*;

  localparam int NB = ACLIA_BYTES;
  localparam int DEPTH = 8 * ENTRIES;
  localparam int AW = $clog2(DEPTH);

  if (PORTS < 1 || PORTS > 7 || ENTRIES != 16)
  begin : g_bad_cfg
    $error("aclia_top: unsupported port or entry count");
  end

  logic [7:0] index_sel;
  logic [7:0] offset;
  logic [13:0] byte_select_mask;
  logic [3:0] entry;
  logic dir_write;
  logic write_done;
  logic read_done;
  logic redundancy_ring_frames_miss;
  logic [7:0] hold_buf [NB];
  aclia_state_e state;
  logic [3:0] step;
  logic [AW-1:0] xfer_addr;
  logic [AW-1:0] launch_addr;
  logic [7:0] lane_rdata [NB];

  // decoding
  wire space_ok = index_sel[7:ACLIA_SPACE_POS] == ACLIA_SPACE_RULES;
  wire [3:0] port_num = index_sel[3:0];
  wire port_ok = port_num >= 4'h1 && port_num <= 4'(PORTS);
  wire sel_ok = space_ok && port_ok;
  wire data_wr = req_i.wr && req_i.addr == ACLIA_ADDR_DATA && sel_ok;
  wire buf_hit = offset <= ACLIA_OFF_BUF_LAST;
  wire busy = state != ACLIA_IDLE;
  wire wr_buf = data_wr && buf_hit && !busy;
  wire wr_msb = data_wr && offset == ACLIA_OFF_MASK_MSB;
  wire wr_lsb = data_wr && offset == ACLIA_OFF_MASK_LSB;
  wire wr_ctrl = data_wr && offset == ACLIA_OFF_CTRL && !busy;
  wire wr_ctrl2 = data_wr && offset == ACLIA_OFF_CTRL_TWO;
  wire [2:0] port_idx = 3'(port_num - 4'h1);
  wire [3:0] buf_idx = offset[3:0];
  wire [AW-1:0] sel_addr = AW'({port_idx, req_i.wdata[3:0]});

  wire [7:0] ctrl_view = {1'b0, write_done, read_done, dir_write, entry};
  wire [7:0] ctrl2_view = {7'h00, redundancy_ring_frames_miss};
  wire [7:0] data_view =
    !sel_ok ? 8'h00 :
    buf_hit ? hold_buf[buf_idx] :
    offset == ACLIA_OFF_MASK_MSB ? {2'b00, byte_select_mask[13:8]} :
    offset == ACLIA_OFF_MASK_LSB ? byte_select_mask[7:0] :
    offset == ACLIA_OFF_CTRL ? ctrl_view :
    offset == ACLIA_OFF_CTRL_TWO ? ctrl2_view : 8'h00;
  wire [7:0] next_rdata =
    req_i.addr == ACLIA_ADDR_INDEX ? index_sel :
    req_i.addr == ACLIA_ADDR_OFFSET ? offset :
    req_i.addr == ACLIA_ADDR_DATA ? data_view : 8'h00;

  // host-side registers
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      index_sel <= ACLIA_INDEX_RST;
      offset <= ACLIA_OFFSET_RST;
      byte_select_mask <= ACLIA_MASK_RST;
      redundancy_ring_frames_miss <= 1'b0;
      rdata_o <= 8'h00;
    end
    else
    begin
      if (req_i.wr && req_i.addr == ACLIA_ADDR_INDEX)
        index_sel <= req_i.wdata;
      if (req_i.wr && req_i.addr == ACLIA_ADDR_OFFSET)
        offset <= req_i.wdata;
      if (wr_msb)
        byte_select_mask[13:8] <= req_i.wdata[5:0] & ACLIA_MASK_MSB_BITS;
      if (wr_lsb)
        byte_select_mask[7:0] <= req_i.wdata;
      if (wr_ctrl2)
        redundancy_ring_frames_miss <= req_i.wdata[0];
      if (req_i.rd)
        rdata_o <= next_rdata;
    end
  end

  assign launch_addr = sel_addr;

  // transfer engine: one byte position per cycle
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      state <= ACLIA_IDLE;
      step <= 4'h0;
      entry <= ACLIA_ENTRY_RST;
      dir_write <= 1'b0;
      write_done <= 1'b1;
      read_done <= 1'b1;
      xfer_addr <= '0;
    end
    else
    begin
      case (state)
        ACLIA_IDLE:
        begin
          if (wr_ctrl)
          begin
            entry <= req_i.wdata[3:0];
            dir_write <= req_i.wdata[ACLIA_DIR_POS];
            xfer_addr <= launch_addr;
            step <= 4'h0;
            if (req_i.wdata[ACLIA_DIR_POS])
            begin
              state <= ACLIA_WRITE;
              write_done <= 1'b0;
            end
            else
            begin
              state <= ACLIA_READ;
              read_done <= 1'b0;
            end
          end
        end
        ACLIA_WRITE:
        begin
          step <= step + 4'h1;
          if (step == 4'(NB - 1))
          begin
            state <= ACLIA_IDLE;
            write_done <= 1'b1;
          end
        end
        ACLIA_READ:
        begin
          // memory read data lags one cycle: extra final cycle
          step <= step + 4'h1;
          if (step == 4'(NB))
          begin
            state <= ACLIA_IDLE;
            read_done <= 1'b1;
          end
        end
        default:
          state <= ACLIA_IDLE;
      endcase
    end
  end

  // holding buffer and byte lanes
  for (genvar i = 0; i < NB; i++)
  begin : g_lane
    // mask bit 13 - i governs byte i
    wire lane_en = byte_select_mask[13 - i];
    wire lane_we = state == ACLIA_WRITE && step == 4'(i) && lane_en;
    // read data valid one cycle after the lane's step
    wire lane_ld = state == ACLIA_READ && step == 4'(i + 1) && lane_en;

    aclia_entry_mem #(
      .DEPTH(DEPTH),
      .AW(AW)
    ) u_mem (
      .sys_clk_i(sys_clk_i),
      .we_i(lane_we),
      .waddr_i(xfer_addr),
      .wdata_i(hold_buf[i]),
      .raddr_i(xfer_addr),
      .rdata_o(lane_rdata[i])
    );

    always_ff @(posedge sys_clk_i)
    begin
      if (!rst_b_i)
        hold_buf[i] <= 8'h00;
      else if (lane_ld)
        hold_buf[i] <= lane_rdata[i];
      else if (wr_buf && buf_idx == 4'(i))
        hold_buf[i] <= req_i.wdata;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      single_entry_redundancy_miss_o <= 1'b0;
      host_read_dir_o <= 1'b0;
    end
    else
    begin
      single_entry_redundancy_miss_o <= redundancy_ring_frames_miss;
      host_read_dir_o <= index_sel[ACLIA_HOSTDIR_POS];
    end
  end
endmodule // aclia_top
`default_nettype wire

/* dv/acl_table_indirect_access_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module acl_table_indirect_access_tb;
  import aclia_pkg::*;
  logic sys_clk_i;
  logic rst_b_i;
  aclia_req_s req;
  logic [7:0] rdata;
  logic miss;
  logic hdir;
  int failures;
  int cmp_count;
  aclia_host hst (.sys_clk_i(sys_clk_i), .req_o(req), .rdata_i(rdata));
  aclia_top i_aclia_top (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .req_i(req), .rdata_o(rdata), .single_entry_redundancy_miss_o(miss),
    .host_read_dir_o(hdir));
  initial
  begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    if (failures == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic sel(input logic [7:0] i, input logic [7:0] o);
    hst.wr(ACLIA_ADDR_INDEX, i);
    hst.wr(ACLIA_ADDR_OFFSET, o);
  endtask
  task automatic put(input logic [7:0] o, input logic [7:0] d);
    sel(8'h41, o);
    hst.wr(ACLIA_ADDR_DATA, d);
  endtask
  task automatic rdc(input logic [7:0] exp);
    logic [7:0] q;
    hst.rd(ACLIA_ADDR_DATA, q);
    chk(q, exp);
  endtask
  task automatic ld(input logic [7:0] b);
    for (int k = 0; k < ACLIA_BYTES; k++)
      put(8'(k), b & (8'hA0 + 8'(k)));
  endtask
  initial
  begin
    #200000;
    failures++;
    final_report;
  end
  initial
  begin
    failures = 0;
    cmp_count = 0;
    rst_b_i = 1'b0;
    repeat (8) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    sel(8'h51, ACLIA_OFF_CTRL);
    rdc(8'h60);
    chk({7'h00, hdir}, 8'h01);
    put(ACLIA_OFF_MASK_MSB, 8'hFF);
    rdc(8'h3F);
    chk({7'h00, hdir}, 8'h00);
    put(ACLIA_OFF_MASK_LSB, 8'hFF);
    ld(8'hFF);
    sel(8'h51, 8'h05);
    rdc(8'hA5);
    put(ACLIA_OFF_CTRL, 8'h1F);
    rdc(8'h3F);
    hst.poll(ACLIA_WDONE_POS);
    rdc(8'h7F);
    ld(8'h00);
    put(ACLIA_OFF_MASK_MSB, 8'h15);
    put(ACLIA_OFF_MASK_LSB, 8'h55);
    put(ACLIA_OFF_CTRL, 8'h0F);
    rdc(8'h4F);
    hst.poll(ACLIA_RDONE_POS);
    for (int i = 0; i < ACLIA_BYTES; i++)
    begin
      sel(8'h51, 8'(i));
      rdc(i[0] ? 8'hA0 + 8'(i) : 8'h00);
    end
    put(ACLIA_OFF_CTRL_TWO, 8'h01);
    rdc(8'h01);
    chk({7'h00, miss}, 8'h01);
    sel(8'h21, 8'h00);
    rdc(8'h00);
    sel(8'h46, ACLIA_OFF_CTRL_TWO);
    rdc(8'h00);
    final_report;
  end
endmodule // acl_table_indirect_access_tb
`default_nettype wire

/* dv/aclia_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module aclia_checker
  import aclia_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // watched ports
  input wire aclia_pkg::aclia_req_s req_i,
  input wire logic [7:0] rdata_o,
  input wire logic single_entry_redundancy_miss_o,
  input wire logic host_read_dir_o
);
  logic [7:0] idx;
  logic [7:0] off;
  logic [4:0] cnt;
  logic wdir;
  wire ok = idx[7:5] == 3'h2 && idx[3:0] != 4'h0 && idx[3:0] < 4'h6;
  wire dw = req_i.wr && req_i.addr == ACLIA_ADDR_DATA && ok;
  wire dr = req_i.rd && req_i.addr == ACLIA_ADDR_DATA;
  wire w6e = req_i.wr && req_i.addr == ACLIA_ADDR_INDEX;
  wire m13 = dw && off == ACLIA_OFF_CTRL_TWO;
  wire rc = dr && ok && off == ACLIA_OFF_CTRL;
  // shadow of index, offset and transfer span
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      idx <= 8'h00;
      off <= 8'h00;
      cnt <= 5'h00;
      wdir <= 1'b0;
    end
    else
    begin
      if (w6e)
        idx <= req_i.wdata;
      if (req_i.wr && req_i.addr == ACLIA_ADDR_OFFSET)
        off <= req_i.wdata;
      if (dw && off == ACLIA_OFF_CTRL && cnt == 5'h00)
      begin
        // cycles until the engine is idle: write 14, read 15
        cnt <= req_i.wdata[4] ? 5'h0E : 5'h0F;
        wdir <= req_i.wdata[4];
      end
      else if (cnt != 5'h00)
        cnt <= cnt - 5'h01;
    end
  end
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  a_dir_copy: assert property (
    w6e ##1 !w6e |-> ##1 host_read_dir_o == $past(req_i.wdata[4], 2))
    else $error("host direction output wrong");
  a_miss_copy: assert property (
    m13 ##1 !m13 |-> ##1
    single_entry_redundancy_miss_o == $past(req_i.wdata[0], 2))
    else $error("redundancy miss output wrong");
  a_idle_done: assert property (
    rc && cnt == 5'h00 |=> rdata_o[7:5] == 3'h3)
    else $error("done flags low while idle");
  a_busy_done: assert property (
    rc && cnt != 5'h00 |=> rdata_o[6:5] == (wdir ? 2'h1 : 2'h2))
    else $error("done flags wrong while busy");
  a_two_rsvd: assert property (
    dr && ok && off == ACLIA_OFF_CTRL_TWO |=> rdata_o[7:1] == 7'h00)
    else $error("second control reserved bits set");
  a_msb_rsvd: assert property (
    dr && ok && off == ACLIA_OFF_MASK_MSB |=> rdata_o[7:6] == 2'h0)
    else $error("mask upper reserved bits set");
  a_bad_space: assert property (
    dr && !ok |=> rdata_o == 8'h00)
    else $error("read outside rule space not zero");
  a_rdata_hold: assert property (
    !req_i.rd ##1 !req_i.rd |=> $stable(rdata_o))
    else $error("read data moved without a read");
endmodule // aclia_checker
bind aclia_top aclia_checker i_aclia_checker (
  .sys_clk_i(sys_clk_i),
  .rst_b_i(rst_b_i),
  .req_i(req_i),
  .rdata_o(rdata_o),
  .single_entry_redundancy_miss_o(single_entry_redundancy_miss_o),
  .host_read_dir_o(host_read_dir_o)
);
`default_nettype wire

/* dv/aclia_host.sv */
`timescale 1ns/1ps
`default_nettype none
module aclia_host
  import aclia_pkg::*;
(
  // clock
  input wire logic sys_clk_i,
  // register port
  output var aclia_pkg::aclia_req_s req_o,
  input wire logic [7:0] rdata_i
);
  initial req_o = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    req_o <= '{1'b1, 1'b0, a, d};
    @(posedge sys_clk_i);
    req_o <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge sys_clk_i);
    req_o <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk_i);
    req_o <= '0;
    @(posedge sys_clk_i);
    #1 q = rdata_i;
  endtask
  // wait on a done flag before touching the buffer
  task automatic poll(input int b);
    logic [7:0] q;
    q = 8'h00;
    for (int n = 0; n < 40 && !q[b]; n++)
      rd(ACLIA_ADDR_DATA, q);
  endtask
endmodule // aclia_host
`default_nettype wire

/* inc/aclia_pkg.sv */
package aclia_pkg;
  localparam int ACLIA_PORTS = 5;
  localparam int ACLIA_ENTRIES = 16;
  localparam int ACLIA_BYTES = 14;
  localparam logic [7:0] ACLIA_ADDR_INDEX = 8'h6E;
  localparam logic [7:0] ACLIA_ADDR_OFFSET = 8'h6F;
  localparam logic [7:0] ACLIA_ADDR_DATA = 8'hA0;
  localparam logic [2:0] ACLIA_SPACE_RULES = 3'h2;
  localparam int ACLIA_SPACE_POS = 5;
  localparam int ACLIA_HOSTDIR_POS = 4;
  localparam logic [7:0] ACLIA_OFF_BUF_LAST = 8'h0D;
  localparam logic [7:0] ACLIA_OFF_MASK_MSB = 8'h10;
  localparam logic [7:0] ACLIA_OFF_MASK_LSB = 8'h11;
  localparam logic [7:0] ACLIA_OFF_CTRL = 8'h12;
  localparam logic [7:0] ACLIA_OFF_CTRL_TWO = 8'h13;
  localparam int ACLIA_WDONE_POS = 6;
  localparam int ACLIA_RDONE_POS = 5;
  localparam int ACLIA_DIR_POS = 4;
  localparam logic [5:0] ACLIA_MASK_MSB_BITS = 6'h3F;
  localparam logic [7:0] ACLIA_INDEX_RST = 8'h00;
  localparam logic [7:0] ACLIA_OFFSET_RST = 8'h00;
  localparam logic [13:0] ACLIA_MASK_RST = 14'h0000;
  localparam logic [3:0] ACLIA_ENTRY_RST = 4'h0;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } aclia_req_s;

  typedef enum logic [1:0] {
    ACLIA_IDLE = 2'b00,
    ACLIA_READ = 2'b01,
    ACLIA_WRITE = 2'b10
  } aclia_state_e;
endpackage
